// ---- hdl/byte_tx_shifter.v ----
/*
  Serialises read bytes onto the I/O lines, one bit or one nibble per
  falling serial clock edge, most significant bit first.
  Assumes shift_i pulses once per falling edge and clear_i while idle.
*/
`timescale 1ns/1ns
module byte_tx_shifter (
  input  wire       clk_i,
  input  wire       rst_i,
  input  wire       clear_i,
  input  wire       shift_i,
  input  wire       quad_i,
  input  wire [7:0] byte_i,
  output reg  [3:0] sio_o,
  output reg  [3:0] sio_oe_o,
  output reg  [1:0] byte_idx_o
);

  reg  [7:0] sh_r;
  reg  [2:0] bit_r;
  wire [7:0] src_w  = (bit_r == 3'h0) ? byte_i : sh_r;
  wire [2:0] step_w = quad_i ? 3'h4 : 3'h1;
  wire [2:0] next_w = bit_r + step_w;

  always @(posedge clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      sh_r       <= 8'h00;
      bit_r      <= 3'h0;
      sio_o      <= 4'h0;
      sio_oe_o   <= 4'h0;
      byte_idx_o <= 2'h0;
    end
    else if (clear_i)
    begin
      bit_r      <= 3'h0;
      sio_o      <= 4'h0;
      sio_oe_o   <= 4'h0;
      byte_idx_o <= 2'h0;
    end
    else if (shift_i)
    begin
      bit_r <= next_w;
      if (next_w == 3'h0)
        byte_idx_o <= byte_idx_o + 2'h1;
      if (quad_i)
      begin
        sio_o    <= src_w[7:4];
        sh_r     <= {src_w[3:0], 4'h0};
        sio_oe_o <= 4'hF;
      end
      else
      begin
        // Single-line reads leave on line 1 only
        sio_o    <= {2'b00, src_w[7], 1'b0};
        sh_r     <= {src_w[6:0], 1'b0};
        sio_oe_o <= 4'h2;
      end
    end
  end

endmodule // byte_tx_shifter

// ---- hdl/flash_cmd_regs.vh ----
/*
  Opcodes, register bit positions, write masks and reset values for the
  register and setting command decoder.
  Assumes inclusion by the decoder files only; definitions only.
*/
`ifndef FLASH_CMD_REGS_VH
`define FLASH_CMD_REGS_VH

`define OP_SET_WRITE_LATCH   8'h06
`define OP_CLEAR_WRITE_LATCH 8'h04
`define OP_READ_STATUS       8'h05
`define OP_READ_CONFIG       8'h15
`define OP_WRITE_STAT_CFG    8'h01
`define OP_READ_UPPER_ADDR   8'hC8
`define OP_WRITE_UPPER_ADDR  8'hC5
`define OP_BLOCK_PROTECT_SEL 8'h68
`define OP_ENTER_QUAD        8'h35
`define OP_LEAVE_QUAD        8'hF5
`define OP_ENTER_WIDE_ADDR   8'hB7
`define OP_LEAVE_WIDE_ADDR   8'hE9
`define OP_SUSPEND           8'hB0
`define OP_RESUME            8'h30
`define OP_SLEEP             8'hB9
`define OP_BURST_LENGTH      8'hC0
`define OP_READ_BOOT         8'h16
`define OP_WRITE_BOOT        8'h17
`define OP_ERASE_BOOT        8'h18

`define STAT_BUSY_BIT        0
`define STAT_LATCH_BIT       1
`define STAT_WRITE_MASK      8'hFC
`define CFG_WIDE_BIT         5
`define CFG_WRITE_MASK       8'hDF

`define STATUS_RESET         8'h00
`define CONFIG_RESET         8'h00
`define UPPER_ADDR_RESET     8'h00
`define BURST_RESET          8'h00
`define BOOT_RESET           32'hFFFFFFFF

`define SYNC_STAGES          2

`endif

// ---- hdl/flash_setting_command_decoder.v ----
/*
  Register and setting command decoder of a serial multi-I/O flash:
  samples chip select, serial clock and I/O lines, decodes one-byte
  opcodes, holds the setting registers and shifts out register reads.
  Assumes serial clock mode 0, a host far slower than mclk_i, and
  array logic on the same clock that reports busy_i.
*/
// Summary of operation
// RULE1: Opcode 06 sets the write latch in either mode, no extra bytes.
// RULE2: Opcode 04 clears the write latch in either mode, no extra bytes.
// RULE3: Opcode 05 shifts out the status register in either mode.
// RULE4: Opcode 15 shifts out the configuration register in either mode.
// RULE5: Opcode 01 with one or two bytes loads status, then configuration.
// RULE6: Opcode C8 returns the upper address register in either mode.
// RULE7: Opcode C5 with exactly one byte stores the upper address register.
// RULE8: Opcode 68, single-line only, enables individual block protection.
// RULE9: Opcode 35, single-line only, enters quad command mode.
// RULE10: Opcode F5, quad mode only, returns to single-line command mode.
// RULE11: Opcode B7 enters four-byte addressing and sets the wide bit.
// RULE12: Opcode E9 returns to three-byte addressing, clears the wide bit.
// RULE13: B0 suspends a running program or erase, 30 resumes it.
// RULE14: Opcode B9 enters deep power-down in either mode.
// RULE15: Opcode C0 sets the wrap-around burst length in either mode.
// RULE16: Boot register: 16 reads 1-4 bytes, 17 writes four, 18 erases.
// RULE17: Opcodes sent in a mode that refuses them change nothing.
// RULE18: Host sets the write latch before any register-modifying command; the decoder checks it only for 01, C5, 17 and 18.
`timescale 1ns/1ns
`include "flash_cmd_regs.vh"
module flash_setting_command_decoder (
  input  wire        mclk_i,
  input  wire        rst_i,
  input  wire        cs_n_i,
  input  wire        sclk_i,
  input  wire [3:0]  sio_i,
  input  wire        busy_i,
  input  wire        wake_i,
  output wire [3:0]  sio_o,
  output wire [3:0]  sio_oe_o,
  output reg  [7:0]  status_o,
  output reg  [7:0]  config_o,
  output reg  [7:0]  upper_addr_o,
  output reg  [7:0]  burst_len_o,
  output reg  [31:0] boot_reg_o,
  output reg         write_latch_bit_o,
  output reg         quad_command_mode_o,
  output reg         wide_address_bit_o,
  output reg         block_protect_o,
  output reg         suspended_o,
  output reg         sleep_o
);

  // Synchronised pins: {cs_n, sclk, sio[3:0]}
  wire [5:0] pins_s;
  wire       cs_n_s = pins_s[5];
  wire       sclk_s = pins_s[4];
  wire [3:0] sio_s  = pins_s[3:0];

  reg        sclk_d_r;
  reg        cs_n_d_r;
  wire       sclk_rise = sclk_s & ~sclk_d_r;
  wire       sclk_fall = ~sclk_s & sclk_d_r;
  wire       cs_rise   = cs_n_s & ~cs_n_d_r;

  // Receive side
  reg  [7:0]  rx_sh_r;
  reg  [2:0]  rx_bit_r;
  reg  [2:0]  byte_cnt_r;
  reg  [7:0]  opcode_r;
  reg  [31:0] data_r;
  reg         reading_r;

  wire [2:0]  rx_step   = quad_command_mode_o ? 3'h4 : 3'h1;
  wire [2:0]  rx_next   = rx_bit_r + rx_step;
  wire [7:0]  rx_byte   = quad_command_mode_o ?
                          {rx_sh_r[3:0], sio_s} :
                          {rx_sh_r[6:0], sio_s[0]};
  wire        rx_done   = sclk_rise & ~cs_n_s & ~reading_r &
                          (rx_next == 3'h0);
  wire [2:0]  data_n    = byte_cnt_r - 3'h1;

  // Read data source
  wire [1:0]  tx_idx;
  reg  [7:0]  tx_byte;

  // Sync resets to the idle pins: cs high, sclk low
  pin_sync #(
    .W       (6),
    .RST_VAL (6'h2F)
  ) u_pin_sync (
    .clk_i (mclk_i),
    .rst_i (rst_i),
    .d_i   ({cs_n_i, sclk_i, sio_i}),
    .q_o   (pins_s)
  );

  byte_tx_shifter u_tx (
    .clk_i      (mclk_i),
    .rst_i      (rst_i),
    .clear_i    (cs_n_s),
    .shift_i    (sclk_fall & reading_r & ~cs_n_s),
    .quad_i     (quad_command_mode_o),
    .byte_i     (tx_byte),
    .sio_o      (sio_o),
    .sio_oe_o   (sio_oe_o),
    .byte_idx_o (tx_idx)
  );

  // Mode check for an opcode of this group
  function accepted;
    input [7:0] op;
    input       quad;
    begin
      case (op)
        `OP_BLOCK_PROTECT_SEL,
        `OP_ENTER_QUAD,
        `OP_READ_BOOT,
        `OP_WRITE_BOOT,
        `OP_ERASE_BOOT:       accepted = ~quad; // RULE17
        `OP_LEAVE_QUAD:       accepted = quad; // RULE17
        `OP_SET_WRITE_LATCH,
        `OP_CLEAR_WRITE_LATCH,
        `OP_READ_STATUS,
        `OP_READ_CONFIG,
        `OP_WRITE_STAT_CFG,
        `OP_READ_UPPER_ADDR,
        `OP_WRITE_UPPER_ADDR,
        `OP_ENTER_WIDE_ADDR,
        `OP_LEAVE_WIDE_ADDR,
        `OP_SUSPEND,
        `OP_RESUME,
        `OP_SLEEP,
        `OP_BURST_LENGTH:     accepted = 1'b1;
        default:              accepted = 1'b0; // RULE17
      endcase
    end
  endfunction

  // Opcodes that answer with data right after the opcode byte
  function is_read;
    input [7:0] op;
    begin
      is_read = (op == `OP_READ_STATUS) ||
                (op == `OP_READ_CONFIG) ||
                (op == `OP_READ_UPPER_ADDR) ||
                (op == `OP_READ_BOOT);
    end
  endfunction

  // Byte presented to the serialiser; register reads repeat
  always @*
  begin
    case (opcode_r)
      `OP_READ_STATUS:
      begin
        tx_byte                  = status_o; // RULE3
        tx_byte[`STAT_LATCH_BIT] = write_latch_bit_o;
        tx_byte[`STAT_BUSY_BIT]  = busy_i;
      end
      `OP_READ_CONFIG:
        tx_byte = config_o; // RULE4
      `OP_READ_UPPER_ADDR:
        tx_byte = upper_addr_o; // RULE6
      `OP_READ_BOOT:
      begin
        // Least significant byte first, wraps after four
        case (tx_idx)
          2'h0:    tx_byte = boot_reg_o[7:0]; // RULE16
          2'h1:    tx_byte = boot_reg_o[15:8];
          2'h2:    tx_byte = boot_reg_o[23:16];
          default: tx_byte = boot_reg_o[31:24];
        endcase
      end
      default:
        tx_byte = 8'h00;
    endcase
  end

  // Edge detectors read only the second sync stage
  // Idle levels after reset, so no false edge follows
  always @(posedge mclk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      sclk_d_r <= 1'b0;
      cs_n_d_r <= 1'b1;
    end
    else
    begin
      sclk_d_r <= sclk_s;
      cs_n_d_r <= cs_n_s;
    end
  end

  // Byte assembly within one chip-select frame
  always @(posedge mclk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      rx_sh_r    <= 8'h00;
      rx_bit_r   <= 3'h0;
      byte_cnt_r <= 3'h0;
      opcode_r   <= 8'h00;
      data_r     <= 32'h00000000;
      reading_r  <= 1'b0;
    end
    else if (cs_n_s)
    begin
      rx_bit_r  <= 3'h0;
      reading_r <= 1'b0;
      if (cs_rise)
        byte_cnt_r <= 3'h0;
    end
    else if (sclk_rise & ~reading_r)
    begin
      rx_sh_r  <= rx_byte;
      rx_bit_r <= rx_next;
      if (rx_done)
      begin
        if (byte_cnt_r != 3'h7)
          byte_cnt_r <= byte_cnt_r + 3'h1;
        if (byte_cnt_r == 3'h0)
        begin
          opcode_r  <= rx_byte;
          // Refused or sleeping: no answer is driven
          reading_r <= is_read(rx_byte) & ~sleep_o &
                       accepted(rx_byte, quad_command_mode_o); // RULE17
        end
        else
          data_r <= {data_r[23:0], rx_byte};
      end
    end
  end

  // Commands take effect when chip select rises on a byte boundary;
  // a frame cut mid-byte is dropped so a glitch cannot write.
  wire commit = cs_rise & (byte_cnt_r != 3'h0) & (rx_bit_r == 3'h0) &
                ~sleep_o & accepted(opcode_r, quad_command_mode_o);

  always @(posedge mclk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      status_o            <= `STATUS_RESET;
      config_o            <= `CONFIG_RESET;
      upper_addr_o        <= `UPPER_ADDR_RESET;
      burst_len_o         <= `BURST_RESET;
      boot_reg_o          <= `BOOT_RESET;
      write_latch_bit_o   <= 1'b0;
      quad_command_mode_o <= 1'b0;
      wide_address_bit_o  <= 1'b0;
      block_protect_o     <= 1'b0;
      suspended_o         <= 1'b0;
      sleep_o             <= 1'b0;
    end
    else
    begin
      config_o[`CFG_WIDE_BIT] <= wide_address_bit_o;
      // A command in the same cycle wins over wake
      if (wake_i & ~commit)
        sleep_o <= 1'b0;
      if (commit)
      begin
        case (opcode_r)
          `OP_SET_WRITE_LATCH:
            if (data_n == 3'h0)
              write_latch_bit_o <= 1'b1; // RULE1
          `OP_CLEAR_WRITE_LATCH:
            if (data_n == 3'h0)
              write_latch_bit_o <= 1'b0; // RULE2
          `OP_WRITE_STAT_CFG:
            // Needs the latch set beforehand; latch drops after
            if (write_latch_bit_o)
            begin
              if (data_n == 3'h1)
              begin
                status_o          <= data_r[7:0] & `STAT_WRITE_MASK; // RULE5
                write_latch_bit_o <= 1'b0; // RULE18
              end
              else if (data_n == 3'h2)
              begin
                status_o          <= data_r[15:8] & `STAT_WRITE_MASK; // RULE5
                config_o          <= (data_r[7:0] & `CFG_WRITE_MASK) |
                                     ({7'h00, wide_address_bit_o} <<
                                      `CFG_WIDE_BIT);
                write_latch_bit_o <= 1'b0;
              end
            end
          `OP_WRITE_UPPER_ADDR:
            if (write_latch_bit_o & (data_n == 3'h1))
            begin
              upper_addr_o      <= data_r[7:0]; // RULE7
              write_latch_bit_o <= 1'b0; // RULE18
            end
          `OP_BLOCK_PROTECT_SEL:
            if (data_n == 3'h0)
              block_protect_o <= 1'b1; // RULE8
          `OP_ENTER_QUAD:
            if (data_n == 3'h0)
              quad_command_mode_o <= 1'b1; // RULE9
          `OP_LEAVE_QUAD:
            if (data_n == 3'h0)
              quad_command_mode_o <= 1'b0; // RULE10
          `OP_ENTER_WIDE_ADDR:
            if (data_n == 3'h0)
              wide_address_bit_o <= 1'b1; // RULE11
          `OP_LEAVE_WIDE_ADDR:
            if (data_n == 3'h0)
              wide_address_bit_o <= 1'b0; // RULE12
          `OP_SUSPEND:
            // Nothing to suspend while idle
            if ((data_n == 3'h0) & busy_i)
              suspended_o <= 1'b1; // RULE13
          `OP_RESUME:
            if (data_n == 3'h0)
              suspended_o <= 1'b0; // RULE13
          `OP_SLEEP:
            if (data_n == 3'h0)
              sleep_o <= 1'b1; // RULE14
          `OP_BURST_LENGTH:
            if (data_n == 3'h1)
              burst_len_o <= data_r[7:0]; // RULE15
          `OP_WRITE_BOOT:
            if (write_latch_bit_o & (data_n == 3'h4))
            begin
              boot_reg_o        <= data_r; // RULE16
              write_latch_bit_o <= 1'b0; // RULE18
            end
          `OP_ERASE_BOOT:
            if (write_latch_bit_o & (data_n == 3'h0))
            begin
              boot_reg_o        <= `BOOT_RESET; // RULE16
              write_latch_bit_o <= 1'b0;
            end
          default:
            write_latch_bit_o <= write_latch_bit_o;
        endcase
      end
    end
  end

endmodule // flash_setting_command_decoder

// ---- hdl/pin_sync.v ----
/*
  Two-flop synchroniser for a group of level inputs.
  Assumes the inputs are asynchronous to clk_i; only q_o is read.
*/
`timescale 1ns/1ns
module pin_sync #(
  parameter         W       = 1,
  parameter [W-1:0] RST_VAL = {W{1'b1}}
) (
  input  wire         clk_i,
  input  wire         rst_i,
  input  wire [W-1:0] d_i,
  output reg  [W-1:0] q_o
);

  reg [W-1:0] meta_r;

  // Both stages reset to the idle levels of the pins
  always @(posedge clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      meta_r <= RST_VAL;
      q_o    <= RST_VAL;
    end
    else
    begin
      meta_r <= d_i;
      q_o    <= meta_r;
    end
  end

endmodule // pin_sync

// ---- sim/flash_cmd_asserts.sv ----
/* Checker for the setting command decoder: commit timing, output
   enables, sleep and suspend. Assumes frames of 8+ mclk and no
   wake pulse inside a frame. */
`timescale 1ns/1ns
module flash_cmd_checker (
  input logic        mclk_i,
  input logic        rst_i,
  input logic        cs_n_i,
  input logic        busy_i,
  input logic        wake_i,
  input logic [3:0]  sio_oe_o,
  input logic [7:0]  status_o,
  input logic [7:0]  config_o,
  input logic [7:0]  upper_addr_o,
  input logic [31:0] boot_reg_o,
  input logic        write_latch_bit_o,
  input logic        quad_command_mode_o,
  input logic        wide_address_bit_o,
  input logic        suspended_o,
  input logic        sleep_o
);
  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (rst_i);

  // Commits land only after chip select rises
  a_quiet_frame:
    assert property (!cs_n_i [*8] |-> $stable({status_o, config_o,
      upper_addr_o, boot_reg_o, write_latch_bit_o, quad_command_mode_o}))
    else $error("register moved inside a frame");
  a_cfg_mirror:
    assert property (1'h1 |=> config_o[5] == $past(wide_address_bit_o))
    else $error("config wide bit does not follow");
  a_oe_idle:
    assert property (cs_n_i [*6] |-> sio_oe_o == 4'h0)
    else $error("output enable left on while deselected");
  a_oe_width:
    assert property (|sio_oe_o |->
      sio_oe_o == (quad_command_mode_o ? 4'hF : 4'h2))
    else $error("output enable width wrong for mode");
  a_suspend_busy:
    assert property ($rose(suspended_o) |-> busy_i)
    else $error("suspend taken while idle");
  a_sleep_holds:
    assert property (sleep_o && !wake_i |=> $stable({write_latch_bit_o,
      quad_command_mode_o, upper_addr_o, status_o, boot_reg_o}))
    else $error("state changed while asleep");
  a_write_latch_use:
    assert property ($changed(upper_addr_o) || $changed(boot_reg_o)
      |-> ##[0:1] !write_latch_bit_o)
    else $error("latch not cleared after write");
  a_wake_clear:
    assert property (wake_i |=> !sleep_o)
    else $error("wake did not leave sleep");

  c_quad: cover property ($rose(quad_command_mode_o));
  c_susp: cover property ($rose(suspended_o));
  c_qread: cover property (sio_oe_o == 4'hF);
endmodule // flash_cmd_checker

bind flash_setting_command_decoder flash_cmd_checker u_flash_cmd_checker (
  .mclk_i              (mclk_i),
  .rst_i               (rst_i),
  .cs_n_i              (cs_n_i),
  .busy_i              (busy_i),
  .wake_i              (wake_i),
  .sio_oe_o            (sio_oe_o),
  .status_o            (status_o),
  .config_o            (config_o),
  .upper_addr_o        (upper_addr_o),
  .boot_reg_o          (boot_reg_o),
  .write_latch_bit_o   (write_latch_bit_o),
  .quad_command_mode_o (quad_command_mode_o),
  .wide_address_bit_o  (wide_address_bit_o),
  .suspended_o         (suspended_o),
  .sleep_o             (sleep_o)
);

// ---- sim/flash_host.sv ----
/* Host controller model: chip select, 160 ns serial clock, I/O lines.
   Assumes mode 0 timing and a decoder sampling on mclk_i. */
`timescale 1ns/1ns
module flash_host (
  input  logic       mclk_i,
  input  logic [3:0] dq_i,
  output logic       cs_n_o,
  output logic       sclk_o,
  output logic [3:0] dq_o
);
  initial
  begin
    cs_n_o = 1'h1;
    sclk_o = 1'h0;
    dq_o   = 4'h0;
  end

  // Read bit taken late in the high phase, well after the shift
  task automatic tick(input [3:0] v, output [3:0] r);
    dq_o <= v;
    repeat (4) @(posedge mclk_i);
    sclk_o <= 1'h1;
    repeat (4) @(posedge mclk_i);
    r = dq_i;
    sclk_o <= 1'h0;
  endtask

  task automatic frame(input q, input int n, input [39:0] d,
                       input int nr, output [31:0] rd);
    logic [3:0] r;
    int         i;
    rd = 32'h0;
    cs_n_o <= 1'h0;
    for (i = 0; i < n * (q ? 2 : 8); i++)
    begin
      tick(q ? d[39:36] : {3'h0, d[39]}, r);
      d = q ? d << 4 : d << 1;
    end
    // Lines not meaningful during a read toggle, never hold
    for (i = 0; i < nr * (q ? 2 : 8); i++)
    begin
      tick(~dq_o, r);
      rd = q ? {rd[27:0], r} : {rd[30:0], r[1]};
    end
    dq_o <= ~dq_o;
    cs_n_o <= 1'h1;
    repeat (10) @(posedge mclk_i);
  endtask
endmodule // flash_host

// ---- sim/tb_flash_setting_command_decoder.sv ----
/* Self-checking bench for the setting command decoder.
   Assumes the host model and checker files compiled first. */
`timescale 1ns/1ns
`define CHK(a, b) begin checked++; if ((a) !== (b)) begin err_total++; \
  $display("mismatch %0t got %h want %h", $time, a, b); end end
module tb_flash_setting_command_decoder;
  logic        mclk_i = 1'h0;
  logic        rst_i  = 1'h1;
  logic        busy_i = 1'h0;
  logic        wake_i = 1'h0;
  logic        cs_n;
  logic        sclk;
  logic [3:0]  dq;
  logic [3:0]  sio_o;
  logic [3:0]  sio_oe_o;
  logic [7:0]  status_o;
  logic [7:0]  config_o;
  logic [7:0]  upper_addr_o;
  logic [7:0]  burst_len_o;
  logic [31:0] boot_reg_o;
  logic [31:0] rd;
  logic [5:0]  flags;
  logic [85:0] rows[$];
  logic [7:0]  qn;
  logic [39:0] d;
  logic [5:0]  f;
  logic [31:0] r;
  wire  [31:0] reg_word = {upper_addr_o, burst_len_o, status_o, config_o};
  int          err_total = 0;
  int          checked = 0;

  flash_setting_command_decoder u_flash_setting_command_decoder (
    .mclk_i(mclk_i), .rst_i(rst_i), .cs_n_i(cs_n), .sclk_i(sclk),
    .sio_i(dq), .busy_i(busy_i), .wake_i(wake_i), .sio_o(sio_o),
    .sio_oe_o(sio_oe_o), .status_o(status_o), .config_o(config_o),
    .upper_addr_o(upper_addr_o), .burst_len_o(burst_len_o),
    .boot_reg_o(boot_reg_o), .write_latch_bit_o(flags[5]),
    .quad_command_mode_o(flags[4]), .wide_address_bit_o(flags[3]),
    .block_protect_o(flags[2]), .suspended_o(flags[1]),
    .sleep_o(flags[0]));
  flash_host u_flash_host (.mclk_i(mclk_i), .dq_i(sio_o),
    .cs_n_o(cs_n), .sclk_o(sclk), .dq_o(dq));

  always #10 mclk_i = ~mclk_i;

  // Row code: bit5 busy, bit4 quad, low nibble byte count
  task automatic add(input [7:0] a, input [39:0] b, input [5:0] c,
                     input [31:0] e);
    rows.push_back({a, b, c, e});
  endtask
  task automatic s(input [7:0] a, input [39:0] b);
    u_flash_host.frame(a[4], a[3:0], b << (8 * (5 - a[3:0])), 0, rd);
  endtask
  task automatic rdx(input q, input [7:0] op, input [7:0] e);
    u_flash_host.frame(q, 1, {op, 32'h0}, 1, rd);
    `CHK(rd[7:0], e)
  endtask
  task test_done;
    $display("checked %0d err_total %0d", checked, err_total);
    if (err_total == 0 && checked > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask

  initial
  begin
    repeat (3) @(posedge mclk_i);
    rst_i <= 1'h0;
    repeat (5) @(posedge mclk_i);
    `CHK({flags, boot_reg_o}, {6'h00, 32'hFFFFFFFF})
    add(8'h01, 40'h06, 6'h20, 32'h0);
    add(8'h01, 40'h04, 6'h00, 32'h0);
    add(8'h02, 40'hC555, 6'h00, 32'h0);
    add(8'h01, 40'h06, 6'h20, 32'h0);
    add(8'h02, 40'hC5A5, 6'h00, 32'hA5000000);
    add(8'h01, 40'h06, 6'h20, 32'hA5000000);
    add(8'h03, 40'h01F00C, 6'h00, 32'hA500F00C);
    add(8'h01, 40'hB7, 6'h08, 32'hA500F02C);
    add(8'h01, 40'hE9, 6'h00, 32'hA500F00C);
    add(8'h02, 40'hC003, 6'h00, 32'hA503F00C);
    add(8'h01, 40'hB0, 6'h00, 32'hA503F00C);
    add(8'h21, 40'hB0, 6'h02, 32'hA503F00C);
    add(8'h21, 40'h30, 6'h00, 32'hA503F00C);
    add(8'h01, 40'h06, 6'h20, 32'hA503F00C);
    add(8'h02, 40'h01FF, 6'h00, 32'hA503FC0C);
    add(8'h01, 40'h35, 6'h10, 32'hA503FC0C);
    add(8'h11, 40'h06, 6'h30, 32'hA503FC0C);
    add(8'h11, 40'h18, 6'h30, 32'hA503FC0C);
    add(8'h11, 40'h68, 6'h30, 32'hA503FC0C);
    add(8'h11, 40'hB7, 6'h38, 32'hA503FC2C);
    add(8'h11, 40'hE9, 6'h30, 32'hA503FC0C);
    add(8'h11, 40'h04, 6'h10, 32'hA503FC0C);
    add(8'h11, 40'hF5, 6'h00, 32'hA503FC0C);
    add(8'h01, 40'hF5, 6'h00, 32'hA503FC0C);
    add(8'h01, 40'h68, 6'h04, 32'hA503FC0C);
    add(8'h01, 40'h06, 6'h24, 32'hA503FC0C);
    add(8'h03, 40'hC51122, 6'h24, 32'hA503FC0C);
    add(8'h01, 40'hB9, 6'h25, 32'hA503FC0C);
    add(8'h01, 40'h04, 6'h25, 32'hA503FC0C);
    foreach (rows[k])
    begin
      {qn, d, f, r} = rows[k];
      busy_i <= qn[5];
      s(qn, d);
      `CHK({flags, reg_word}, {f, r})
      $display("row %0d done", k);
    end
    busy_i <= 1'h0;
    wake_i <= 1'h1;
    @(posedge mclk_i);
    wake_i <= 1'h0;
    @(posedge mclk_i);
    `CHK(flags, 6'h24)
    s(8'h05, 40'h17DEADBEEF);
    `CHK(boot_reg_o, 32'hDEADBEEF)
    u_flash_host.frame(0, 1, 40'h1600000000, 4, rd);
    `CHK(rd, 32'hEFBEADDE)
    $display("boot register test done");
    s(8'h01, 40'h06);
    rdx(0, 8'h05, 8'hFE);
    rdx(0, 8'h15, 8'h0C);
    rdx(0, 8'hC8, 8'hA5);
    s(8'h01, 40'h18);
    `CHK(boot_reg_o, 32'hFFFFFFFF)
    s(8'h01, 40'h35);
    rdx(1, 8'hC8, 8'hA5);
    rdx(1, 8'h05, 8'hFC);
    $display("read test done");
    // Reset in mid-run must drop latch and quad mode
    s(8'h11, 40'h06);
    rst_i <= 1'h1;
    repeat (2) @(posedge mclk_i);
    `CHK({flags, upper_addr_o, boot_reg_o}, {14'h0, 32'hFFFFFFFF})
    rst_i <= 1'h0;
    repeat (4) @(posedge mclk_i);
    s(8'h01, 40'h06);
    `CHK(flags, 6'h20)
    busy_i <= 1'h1;
    rdx(0, 8'h05, 8'h03);
    busy_i <= 1'h0;
    $display("reset test done");
    test_done;
  end
endmodule // tb_flash_setting_command_decoder
